// ==== supply_trim_params.svh ====
// Offsets, field positions, reset values and timing figures of the trim block.
`ifndef SUPPLY_TRIM_PARAMS_SVH
`define SUPPLY_TRIM_PARAMS_SVH

// Global register byte addresses.
`define CTRL_OFS 9'h000
`define MODE_OFS 9'h004
`define POL_OFS 9'h008
`define STAT_OFS 9'h00c

// Channel window: address bit 8 set, bits 7:5 channel, bits 4:2 index.
`define CH_WIN_BIT 8
`define CH_SEL_MSB 7
`define CH_SEL_LSB 5
`define IDX_MSB 4
`define IDX_LSB 2

// Channel register indexes; 0 to 3 are the stored profile codes.
`define IDX_HOST 3'h4
`define IDX_LOOP 3'h5
`define IDX_SETPOINT 3'h6

// Control register fields.
`define CTRL_SRC_BIT 0
`define CTRL_RATE_LSB 1
`define CTRL_RATE_MSB 2

// Status register fields.
`define STAT_PROF_LSB 0
`define STAT_PROF_MSB 1
`define STAT_LOOP_BIT 2

// Reset values.
`define CODE_RESET 8'h80
`define CTRL_RESET 3'h0
`define MODE_RESET 16'h0000
`define POL_RESET 8'h00

// Correction intervals in nanoseconds and the clock rate in MHz.
`define UPD0_NS 580000
`define UPD1_NS 1150000
`define UPD2_NS 9220000
`define UPD3_NS 18500000
`define CLK_MHZ 50

`endif

// ==== supply_trim_pkg.sv ====
// Types shared by the trim control top and its channel module.
package supply_trim_pkg;

   // Profile 0 operating mode of one channel.
   typedef enum logic [1:0] {
      MODE_FIXED = 2'h0,
      MODE_HOST = 2'h1,
      MODE_LOOP = 2'h2
   } mode_e;

   // Active voltage profile after decoding the two select bits.
   typedef enum logic [1:0] {
      PROF_0 = 2'h0,
      PROF_1 = 2'h1,
      PROF_2 = 2'h2,
      PROF_3 = 2'h3
   } profile_e;

   // Register bus slave states, one-hot.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_ACK = 2'h2
   } bus_state_e;

   // Per-channel configuration as carried to each channel.
   typedef struct packed {
      logic polarity;
      mode_e mode;
   } chan_cfg_s;

endpackage

// ==== trim_channel.sv ====
// One trim channel: code registers, closed-loop stepper and DAC code mux.
`timescale 1ns/10ps
`include "supply_trim_params.svh"

module trim_channel
   import supply_trim_pkg::*;
#(
   parameter int ADC_W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [2:0] wr_idx_i,
   input wire logic [ADC_W-1:0] wr_data_i,
   input wire logic [2:0] rd_idx_i,
   output logic [ADC_W-1:0] rd_data_o,
   input wire profile_e profile_i,
   input wire chan_cfg_s cfg_i,
   input wire logic loop_en_i,
   input wire logic step_i,
   input wire logic [ADC_W-1:0] adc_i,
   output logic [7:0] dac_code_o
);

   ////////////////////////////////////////////////////////////////////////
   // Six code registers plus the setpoint.

   logic [7:0] prof_code_q [4];
   logic [7:0] prof_code_d [4];
   logic [7:0] host_q, host_d;
   logic [7:0] loop_q, loop_d;
   logic [ADC_W-1:0] setpoint_q, setpoint_d;
   logic [7:0] dac_q, dac_d;
   logic raise;
   logic lower;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         prof_code_d[i] = prof_code_q[i];
         if (wr_en_i && wr_idx_i == 3'(i)) begin
            prof_code_d[i] = wr_data_i[7:0];
         end
      end
      host_d = host_q;
      setpoint_d = setpoint_q;
      loop_d = loop_q;
      // Setpoint above the reading is +1; polarity flips the step.
      raise = 1'b0;
      lower = 1'b0;
      if (setpoint_q != adc_i) begin
         raise = (setpoint_q > adc_i) ^ cfg_i.polarity;
         lower = ~raise;
      end
      if (wr_en_i && wr_idx_i == `IDX_HOST) begin
         host_d = wr_data_i[7:0];
         // Preload is only taken while the loop is stopped.
         if (!loop_en_i) begin
            loop_d = wr_data_i[7:0];
         end
      end
      if (wr_en_i && wr_idx_i == `IDX_SETPOINT) begin
         setpoint_d = wr_data_i;
      end
      // A zero result leaves the code alone; the ends saturate.
      if (loop_en_i && step_i && profile_i == PROF_0 &&
          cfg_i.mode == MODE_LOOP) begin
         if (raise && loop_q != 8'hff) begin
            loop_d = loop_q + 8'h01;
         end else if (lower && loop_q != 8'h00) begin
            loop_d = loop_q - 8'h01;
         end
      end
   end

   // Code selection; an unused mode code falls back to register 0.
   always_comb begin
      if (profile_i != PROF_0) begin
         dac_d = prof_code_q[profile_i];
      end else begin
         case (cfg_i.mode)
            MODE_HOST: dac_d = host_q;
            MODE_LOOP: dac_d = loop_q;
            default: dac_d = prof_code_q[0];
         endcase
      end
   end

   always_comb begin
      rd_data_o = '0;
      if (rd_idx_i < 3'h4) begin
         rd_data_o[7:0] = prof_code_q[rd_idx_i[1:0]];
      end else if (rd_idx_i == `IDX_HOST) begin
         rd_data_o[7:0] = host_q;
      end else if (rd_idx_i == `IDX_LOOP) begin
         rd_data_o[7:0] = loop_q;
      end else if (rd_idx_i == `IDX_SETPOINT) begin
         rd_data_o = setpoint_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            prof_code_q[i] <= `CODE_RESET;
         end
         host_q <= `CODE_RESET;
         loop_q <= `CODE_RESET;
         setpoint_q <= '0;
         dac_q <= `CODE_RESET;
      end else begin
         prof_code_q <= prof_code_d;
         host_q <= host_d;
         loop_q <= loop_d;
         setpoint_q <= setpoint_d;
         dac_q <= dac_d;
      end
   end

   assign dac_code_o = dac_q;

endmodule // trim_channel

// ==== supply_trim_margin_control.sv ====
// Eight-channel supply trim and margin control with a Wishbone register file.
//
// Behaviour
// - Profile source: pins or logic, by setting.
// - One profile drives all eight channels.
// - Bits 11,10,01,00 select profiles 3,2,1,0.
// - Profiles 1-3 use stored code of same index.
// - Six 8-bit codes; four stored, two volatile.
// - Profile 0 mode: fixed, host or loop.
// - Profile 0 mode held per channel.
// - Fixed mode drives stored code 0.
// - Host mode follows host register immediately; the DAC code is registered, one clock behind host register.
// - Host register resets to 80h.
// - One loop enable, from internal logic only.
// - Loop corrects once per selected interval.
// - Compare reading with setpoint: +1, -1, 0.
// - Nonzero result steps loop register by one.
// - Channel polarity sets step direction.
// - Zero result leaves loop register unchanged.
// - Loop mode drives loop register to DAC.
// - Rate codes give 580us,1.15ms,9.22ms,18.5ms.
// - Loop register resets to 80h.
// - Channel N uses monitor reading N only.
// - Host address write preloads loop register while loop is off.
`timescale 1ns/10ps
`include "supply_trim_params.svh"

module supply_trim_margin_control
   import supply_trim_pkg::*;
#(
   parameter int CH_N = 8,
   parameter int ADC_W = 10,
   parameter int CNT_W = 20,
   parameter int RATE0_CYC = (`UPD0_NS * `CLK_MHZ) / 1000,
   parameter int RATE1_CYC = (`UPD1_NS * `CLK_MHZ) / 1000,
   parameter int RATE2_CYC = (`UPD2_NS * `CLK_MHZ) / 1000,
   parameter int RATE3_CYC = (`UPD3_NS * `CLK_MHZ) / 1000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [8:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Profile select from the pins and from the internal logic.
   input wire logic [1:0] pin_profile_select_i,
   input wire logic [1:0] logic_profile_select_i,
   // Closed-loop enable, driven by the internal logic alone.
   input wire logic loop_trim_enable_i,
   // Monitor readings, channel N on slice N.
   input wire logic [CH_N-1:0][ADC_W-1:0] adc_result_i,
   // Trim DAC codes, channel N on slice N.
   output logic [CH_N-1:0][7:0] dac_code_o
);

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   logic [2:0] ctrl_q, ctrl_d;
   logic [15:0] mode_q, mode_d;
   logic [7:0] pol_q, pol_d;

   logic logic_src;
   logic [1:0] rate_sel;

   assign logic_src = ctrl_q[`CTRL_SRC_BIT];
   assign rate_sel = ctrl_q[`CTRL_RATE_MSB:`CTRL_RATE_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Bus decode signals.

   bus_state_e state_q, state_d;
   logic [31:0] dat_q, dat_d;
   logic req;
   logic wr_stb;
   logic ch_hit;
   logic [2:0] ch_sel;
   logic [2:0] ch_idx;
   logic [31:0] byte_mask;
   logic [31:0] cur_val;
   logic [31:0] wr_val;
   logic mapped;
   logic [ADC_W-1:0] ch_rd [CH_N];

   ////////////////////////////////////////////////////////////////////////
   // Profile selection.

   logic [1:0] prof_bits;
   profile_e profile;

   always_comb begin
      // One source feeds every channel, so all stay in one profile.
      if (logic_src) begin
         prof_bits = logic_profile_select_i;
      end else begin
         prof_bits = pin_profile_select_i;
      end
      case (prof_bits)
         2'h3: profile = PROF_3;
         2'h2: profile = PROF_2;
         2'h1: profile = PROF_1;
         default: profile = PROF_0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Correction interval divider.

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] limit;
   logic tick;
   // CNT_W covers the slowest interval at 50 MHz; a faster clock or a
   // longer interval needs a wider counter, or the limit is cut short.

   always_comb begin
      case (rate_sel)
         2'h0: limit = CNT_W'(RATE0_CYC - 1);
         2'h1: limit = CNT_W'(RATE1_CYC - 1);
         2'h2: limit = CNT_W'(RATE2_CYC - 1);
         default: limit = CNT_W'(RATE3_CYC - 1);
      endcase
   end

   // The divider is held at zero while the loop is off, so the first
   // correction comes one full interval after the enable rises. The
   // greater-or-equal test keeps a shortened rate from stranding the count.
   always_comb begin
      tick = 1'b0;
      cnt_d = cnt_q;
      if (!loop_trim_enable_i) begin
         cnt_d = '0;
      end else if (cnt_q >= limit) begin
         cnt_d = '0;
         tick = 1'b1;
      end else begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, then ack for one cycle.
   // A write lands on the edge that accepts it, one cycle ahead of ack;
   // the master still holds every qualifier then, so the data is sound.
   // A request seen while ack is up is ignored, which keeps a master
   // that is slow to drop its strobe from issuing a second transfer.

   assign req = cyc_i && stb_i && state_q == ST_IDLE;
   assign wr_stb = req && we_i;
   assign ch_hit = adr_i[`CH_WIN_BIT];
   assign ch_sel = adr_i[`CH_SEL_MSB:`CH_SEL_LSB];
   assign ch_idx = adr_i[`IDX_MSB:`IDX_LSB];

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         byte_mask[b*8 +: 8] = {8{sel_i[b]}};
      end
   end

   // Current value at the address; unmapped words read as zero.
   always_comb begin
      cur_val = 32'h0000_0000;
      mapped = 1'b1;
      if (ch_hit) begin
         if (ch_idx <= `IDX_SETPOINT) begin
            cur_val[ADC_W-1:0] = ch_rd[ch_sel];
         end else begin
            mapped = 1'b0;
         end
      end else if (adr_i == `CTRL_OFS) begin
         cur_val[2:0] = ctrl_q;
      end else if (adr_i == `MODE_OFS) begin
         cur_val[15:0] = mode_q;
      end else if (adr_i == `POL_OFS) begin
         cur_val[7:0] = pol_q;
      end else if (adr_i == `STAT_OFS) begin
         cur_val[`STAT_PROF_MSB:`STAT_PROF_LSB] = profile;
         cur_val[`STAT_LOOP_BIT] = loop_trim_enable_i;
      end else begin
         mapped = 1'b0;
      end
   end

   // Lanes not selected keep their old contents.
   assign wr_val = (cur_val & ~byte_mask) | (dat_i & byte_mask);

   always_comb begin
      state_d = state_q;
      dat_d = dat_q;
      case (state_q)
         ST_IDLE: begin
            if (req) begin
               state_d = ST_ACK;
               dat_d = we_i ? 32'h0000_0000 : cur_val;
            end
         end
         ST_ACK: begin
            state_d = ST_IDLE;
            dat_d = 32'h0000_0000;
         end
         default: begin
            state_d = ST_IDLE;
            dat_d = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         dat_q <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         dat_q <= dat_d;
      end
   end

   assign ack_o = state_q == ST_ACK;
   assign dat_o = dat_q;

   ////////////////////////////////////////////////////////////////////////
   // Global configuration writes.

   always_comb begin
      ctrl_d = ctrl_q;
      mode_d = mode_q;
      pol_d = pol_q;
      if (wr_stb && !ch_hit && mapped) begin
         if (adr_i == `CTRL_OFS) begin
            ctrl_d = wr_val[2:0];
         end else if (adr_i == `MODE_OFS) begin
            mode_d = wr_val[15:0];
         end else if (adr_i == `POL_OFS) begin
            pol_d = wr_val[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `CTRL_RESET;
         mode_q <= `MODE_RESET;
         pol_q <= `POL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         mode_q <= mode_d;
         pol_q <= pol_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels. The loop register is read-only on the bus; it is loaded
   // through the host address while the loop is stopped. Mode code 3 is
   // treated as fixed register 0, so a stray code never leaves a trim open.

   genvar g;
   generate
      for (g = 0; g < CH_N; g++) begin : g_ch
         chan_cfg_s cfg;
         logic ch_wr;

         always_comb begin
            cfg.polarity = pol_q[g];
            // Per-channel two-bit mode field.
            cfg.mode = mode_e'(mode_q[2*g +: 2]);
            ch_wr = wr_stb && ch_hit && mapped && ch_sel == 3'(g) &&
                    ch_idx != `IDX_LOOP;
         end

         trim_channel #(
            .ADC_W(ADC_W)
         ) u_trim_channel (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_en_i(ch_wr),
            .wr_idx_i(ch_idx),
            .wr_data_i(wr_val[ADC_W-1:0]),
            .rd_idx_i(ch_idx),
            .rd_data_o(ch_rd[g]),
            .profile_i(profile),
            .cfg_i(cfg),
            .loop_en_i(loop_trim_enable_i),
            .step_i(tick),
            .adc_i(adc_result_i[g]),
            .dac_code_o(dac_code_o[g])
         );
      end
   endgenerate

endmodule // supply_trim_margin_control

// ==== trim_supply_model.sv ====
// Behavioural bank of trimmed converters feeding the monitor readings.
`timescale 1ns/10ps

module trim_supply_model #(
   parameter int CH_N = 8,
   parameter int ADC_W = 10
) (
   input wire logic clk_i,
   input wire logic [CH_N-1:0][7:0] dac_code_i,
   output logic [CH_N-1:0][ADC_W-1:0] adc_result_o
);
   // Each converter settles one clock after its trim code moves, so the
   // reading lags the code; the loop only samples once per interval.
   always_ff @(posedge clk_i) begin
      for (int n = 0; n < CH_N; n++) begin
         adc_result_o[n] <= ADC_W'(dac_code_i[n]);
      end
   end
endmodule // trim_supply_model

// ==== supply_trim_margin_control_checker.sv ====
// Port-level assertions for the trim control top.
`timescale 1ns/10ps
`include "supply_trim_params.svh"

module supply_trim_margin_control_checker #(
   parameter int CH_N = 8,
   parameter int ADC_W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [8:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic [1:0] pin_profile_select_i,
   input wire logic [1:0] logic_profile_select_i,
   input wire logic loop_trim_enable_i,
   input wire logic [CH_N-1:0][ADC_W-1:0] adc_result_i,
   input wire logic [CH_N-1:0][7:0] dac_code_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic no_wr = !(cyc_i && stb_i && we_i);
   wire logic rd_new = cyc_i && stb_i && !we_i && !ack_o;
   ////////////////////////////////////////////////////////////
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (
      (cyc_i && stb_i && !ack_o && !$past(ack_o)) |=> ack_o)
      else $error("request not answered next cycle");
   ack_cause_a: assert property (
      ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   dac_reset_a: assert property (disable iff (1'b0)
      rst_i |=> dac_code_o == {CH_N{8'h80}})
      else $error("trim codes not at midscale after reset");
   stat_enable_a: assert property (
      (rd_new && adr_i == `STAT_OFS && !$past(ack_o))
      |=> dat_o[`STAT_LOOP_BIT] == $past(loop_trim_enable_i))
      else $error("status enable bit wrong");
   unmapped_zero_a: assert property (
      (rd_new && adr_i[8] && adr_i[4:2] == 3'h7) |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
   quiet_hold_a: assert property (
      (!loop_trim_enable_i && no_wr && $stable(pin_profile_select_i)
      && $stable(logic_profile_select_i)) [*3] |=> $stable(dac_code_o))
      else $error("trim code moved without cause");
   for (genvar g = 0; g < CH_N; g++) begin : g_ch
      step_one_a: assert property (
         (loop_trim_enable_i && no_wr && $stable(pin_profile_select_i)
         && $stable(logic_profile_select_i)) [*3]
         |=> ({1'b0, dac_code_o[g]} - {1'b0, $past(dac_code_o[g])})
         inside {9'h000, 9'h001, 9'h1ff})
         else $error("loop step larger than one or wrapped");
   end
endmodule // supply_trim_margin_control_checker

bind supply_trim_margin_control supply_trim_margin_control_checker #(
   .CH_N(CH_N), .ADC_W(ADC_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .pin_profile_select_i(pin_profile_select_i),
   .logic_profile_select_i(logic_profile_select_i),
   .loop_trim_enable_i(loop_trim_enable_i),
   .adc_result_i(adc_result_i), .dac_code_o(dac_code_o));

// ==== test_supply_trim_margin_control.sv ====
// Self-checking bench for the eight-channel trim control block.
`timescale 1ns/10ps
`include "supply_trim_params.svh"

module test_supply_trim_margin_control;
   localparam int CH_N = 8;
   localparam logic [9:0] SP [8] = '{10'h0, 10'h0, 10'h085, 10'h0,
      10'h3ff, 10'h07a, 10'h0, 10'h0};
   localparam logic [7:0] FIN [8] = '{8'h0, 8'h0, 8'h85, 8'hff,
      8'hff, 8'h7a, 8'h0, 8'h0};
   logic clk, rst, cyc, stb, we, ack, loop_en;
   logic [8:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, dat, rdat;
   logic [1:0] pin_sel, logic_sel;
   logic [CH_N-1:0][9:0] adc;
   logic [CH_N-1:0][7:0] dac;
   int err_count, samples_checked;

   supply_trim_margin_control #(.RATE0_CYC(4), .RATE1_CYC(5),
      .RATE2_CYC(6), .RATE3_CYC(7)) u_dut (.clk_i(clk), .rst_i(rst),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(dat), .ack_o(ack),
      .pin_profile_select_i(pin_sel), .logic_profile_select_i(logic_sel),
      .loop_trim_enable_i(loop_en), .adc_result_i(adc),
      .dac_code_o(dac));
   trim_supply_model u_conv (.clk_i(clk), .dac_code_i(dac),
      .adc_result_o(adc));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (err_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [8:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk(n, 32'h1);
      rdat = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [8:0] ca(input int c, input logic [2:0] i);
      return {1'b1, 3'(c), i, 2'b00};
   endfunction
   task automatic wait_chg(output int n);
      logic [7:0] v;
      v = dac[4];
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (dac[4] === v && n < 60);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int c = 0; c < CH_N; c++) chk(dac[c], 8'h80);
      wb(1'b0, ca(0, `IDX_HOST), 0);
      chk(rdat, 32'h80);
      wb(1'b0, ca(7, `IDX_LOOP), 0);
      chk(rdat, 32'h80);
      wb(1'b0, ca(0, 3'h7), 0);
      chk(rdat, 32'h0);
      wb(1'b0, 9'h010, 0);
      chk(rdat, 32'h0);
   endtask
   task automatic t_profiles;
      for (int c = 0; c < CH_N; c++)
         for (int i = 0; i < 4; i++) wb(1'b1, ca(c, 3'(i)), 16 * i + c + 1);
      for (int p = 0; p < 4; p++) begin
         pin_sel <= 2'(p);
         repeat (3) @(posedge clk);
         for (int c = 0; c < CH_N; c++)
            chk(dac[c], 16 * p + c + 1);
      end
      logic_sel <= 2'h2;
      wb(1'b1, `CTRL_OFS, 32'h1);
      repeat (2) @(posedge clk);
      for (int c = 0; c < CH_N; c++) chk(dac[c], 33 + c);
      wb(1'b0, `STAT_OFS, 0);
      chk(rdat[`STAT_PROF_MSB:`STAT_PROF_LSB], 32'h2);
      wb(1'b1, `CTRL_OFS, 32'h0);
      pin_sel <= 2'h0;
   endtask
   task automatic t_modes;
      logic [7:0] e;
      wb(1'b1, `MODE_OFS, 32'he4);
      for (int c = 0; c < CH_N; c++)
         wb(1'b1, ca(c, `IDX_HOST), 8'h40 + c);
      for (int c = 0; c < CH_N; c++) begin
         e = (c == 1) ? 8'h41 : (c == 2) ? 8'h42 : 8'(c + 1);
         chk(dac[c], e);
      end
      wb(1'b1, ca(1, `IDX_HOST), 32'h9c);
      chk(dac[1], 8'h9c);
      sel <= 4'h0;
      wb(1'b1, ca(1, `IDX_HOST), 32'h11);
      sel <= 4'hf;
      chk(dac[1], 8'h9c);
   endtask
   task automatic t_loop;
      int n;
      wb(1'b1, `POL_OFS, 32'h08);
      wb(1'b1, `MODE_OFS, 32'haaaa);
      for (int c = 0; c < CH_N; c++) wb(1'b1, ca(c, `IDX_SETPOINT), SP[c]);
      for (int r = 0; r < 4; r++) begin
         wb(1'b1, `CTRL_OFS, 32'(r) << `CTRL_RATE_LSB);
         wb(1'b1, ca(4, `IDX_HOST), 32'h80);
         loop_en <= 1'b1;
         wait_chg(n);
         wait_chg(n);
         chk(n, 4 + r);
         loop_en <= 1'b0;
      end
      wb(1'b1, `CTRL_OFS, 32'h0);
      for (int c = 0; c < CH_N; c++) wb(1'b1, ca(c, `IDX_HOST), 32'h80);
      loop_en <= 1'b1;
      repeat (700) @(posedge clk);
      wb(1'b0, `STAT_OFS, 0);
      chk(rdat[`STAT_LOOP_BIT], 1'b1);
      for (int c = 0; c < CH_N; c++)
         chk(dac[c], FIN[c]);
      chk(dac[2], 8'h85);
      chk(dac[3], 8'hff);
      loop_en <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rst <= 1'b1;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      adr <= 9'h0;
      sel <= 4'hf;
      wdat <= 32'h0;
      pin_sel <= 2'h0;
      logic_sel <= 2'h0;
      loop_en <= 1'b0;
      err_count = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_profiles;
      t_modes;
      t_loop;
      end_sim;
   end
   initial begin
      #200000;
      err_count++;
      end_sim;
   end
endmodule // test_supply_trim_margin_control
